// file: flash_divider.sv
/*
 * Free-running divider giving the on/off phase of flashing lights.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_divider #(
    parameter int unsigned HALF_CYCLES = 31250000 // cycles per phase
) (
    input  wire logic aclk,        // device clock
    input  wire logic aresetn,     // synchronous reset, low active
    output var  logic flash_on_q   // high in the lit half of the period
);

    logic [31:0] count_q;

    // equal on and off halves, never stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q    <= 32'h0;
            flash_on_q <= 1'b0;
        end else if (count_q == HALF_CYCLES - 1) begin
            count_q    <= 32'h0;
            flash_on_q <= ~flash_on_q;
        end else begin
            count_q <= count_q + 32'h1;
        end
    end

endmodule // flash_divider

`default_nettype wire

// file: hour_counter.sv
/*
 * Accumulating counter of whole hours spent while run is high.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "status_led_cfg.svh"

module hour_counter #(
    parameter int unsigned SEC_CYCLES = 125000000 // cycles per second
) (
    input  wire logic        aclk,     // device clock
    input  wire logic        aresetn,  // synchronous reset, low active
    input  wire logic        run,      // count while high
    output var  logic [31:0] hours_q   // whole hours accumulated
);

    logic [31:0] tick_q;
    logic [11:0] secs_q;

    // partial seconds and hours are kept while run is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q  <= 32'h0;
            secs_q  <= 12'h0;
            hours_q <= 32'h0;
        end else if (run) begin
            if (tick_q == SEC_CYCLES - 1) begin
                tick_q <= 32'h0;
                if (secs_q == 12'(`SECONDS_PER_HOUR - 1)) begin
                    secs_q  <= 12'h0;
                    hours_q <= hours_q + 32'h1;
                end else begin
                    secs_q <= secs_q + 12'h1;
                end
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end

endmodule // hour_counter

`default_nettype wire

// file: panel_watch.sv
/*
 * Panel observer: counts the cycles a light shows one colour.
 * Assumes one clock; clr is held high for one edge to restart.
 */
`timescale 1ns/1ps
`default_nettype none

module panel_watch (
    input  wire logic                       aclk, // device clock
    input  wire logic                       clr,  // restart the count
    input  wire status_led_pkg::led_color_t led,  // light watched
    input  wire status_led_pkg::led_color_t want, // colour looked for
    output var  int                         hits  // lit cycles seen
);
    import status_led_pkg::*;

    // an operator's eye: lit cycles since the last clear
    always_ff @(posedge aclk) begin
        if (clr)
            hits <= 0;
        else if (led === want)
            hits <= hits + 1;
    end
endmodule // panel_watch

`default_nettype wire

// file: status_led_cfg.svh
/*
 * Constants of the panel indicator block: register byte offsets, field
 * positions, reset values and timing figures.
 * Assumes a 125 MHz clock; included by bare name from the hour counter, the indicator logic and the bench.
 */
`ifndef STATUS_LED_CFG_SVH
`define STATUS_LED_CFG_SVH

// clock and timing
`define CLK_PERIOD_NS    8
`define ONE_SECOND_NS    1000000000
`define SEC_CYCLES       (`ONE_SECOND_NS / `CLK_PERIOD_NS)
`define FLASH_HALF_NS    250000000
`define FLASH_CYCLES     (`FLASH_HALF_NS / `CLK_PERIOD_NS)
`define SECONDS_PER_HOUR 3600

// temperature margin beyond the specified range, in degrees C
`define TEMP_MARGIN_C    5

// register byte offsets
`define OFF_CTRL         8'h00
`define OFF_TEMP_LIMIT   8'h04
`define OFF_STATE        8'h08
`define OFF_IRQ_STATUS   8'h0C
`define OFF_IRQ_MASK     8'h10
`define OFF_HOURS        8'h14

// control fields
`define CTRL_TX_EN       0
`define CTRL_WARN_EN     1
`define CTRL_OC_CLEAR    2
`define CTRL_RESET       32'h0000_0003

// temperature limit fields and reset value (low 0 C, high 50 C)
`define LIM_LOW_LSB      0
`define LIM_HIGH_LSB     8
`define LIM_RESET        32'h0000_3200

// event bits of status and mask
`define EV_TEMP_RANGE    0
`define EV_OVERCURRENT   1
`define EV_LASER_EOL     2
`define EV_LINK_ERROR    3
`define EV_WIDTH         4

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: status_led_diagnostics.sv
/*
 * Panel indicator logic of the optical transceiver with AXI4-Lite
 * registers, sticky events and one interrupt line.
 * Assumes condition inputs synchronous to aclk; one write and one read
 * under way at most on the bus.
 */
// Behaviour
// - too hot with warning enabled flashes the power light red.
// - outside range by up to 5 C lights temperature steady orange.
// - outside range by more than 5 C lights temperature steady red.
// - temperature excursions never switch the data path off.
// - time outside the temperature range accumulates in an hour counter.
// - laser near end of life lights the laser light steady orange.
// - overcurrent switches the transmitter off and flashes laser orange.
// - peer link or signal fault lights link error steady orange.
// - own link or signal fault lights link error steady red.
`timescale 1ns/1ps
`default_nettype none
`include "status_led_cfg.svh"

module status_led_diagnostics #(
    parameter int unsigned SEC_CYCLES   = `SEC_CYCLES,   // one second
    parameter int unsigned FLASH_CYCLES = `FLASH_CYCLES  // flash half
) (
    input  wire logic                     aclk,          // clock, 125 MHz
    input  wire logic                     aresetn,       // sync reset, low
    input  wire logic [7:0]               s_axi_awaddr,  // write address
    input  wire logic                     s_axi_awvalid, // write addr valid
    output var  logic                     s_axi_awready, // write addr ready
    input  wire logic [31:0]              s_axi_wdata,   // write data
    input  wire logic [3:0]               s_axi_wstrb,   // byte enables
    input  wire logic                     s_axi_wvalid,  // write data valid
    output var  logic                     s_axi_wready,  // write data ready
    output var  logic [1:0]               s_axi_bresp,   // write response
    output var  logic                     s_axi_bvalid,  // response valid
    input  wire logic                     s_axi_bready,  // response ready
    input  wire logic [7:0]               s_axi_araddr,  // read address
    input  wire logic                     s_axi_arvalid, // read addr valid
    output var  logic                     s_axi_arready, // read addr ready
    output var  logic [31:0]              s_axi_rdata,   // read data
    output var  logic [1:0]               s_axi_rresp,   // read response
    output var  logic                     s_axi_rvalid,  // read data valid
    input  wire logic                     s_axi_rready,  // read data ready
    input  wire logic signed [7:0]        temp_celsius,  // die temperature
    input  wire logic                     device_error,  // hardware fault
    input  wire logic                     laser_eol,     // laser wearing out
    input  wire logic                     laser_overcur, // drive too high
    input  wire logic                     own_link_lost, // own cable down
    input  wire logic                     own_sq_low,    // own signal poor
    input  wire logic                     peer_fault,    // peer reports fault
    output var  status_led_pkg::led_color_t power_state_indicator,  // power
    output var  status_led_pkg::led_color_t temperature_indicator,  // temp
    output var  status_led_pkg::led_color_t laser_health_indicator, // laser
    output var  status_led_pkg::led_color_t link_error_indicator,   // link
    output var  logic                     tx_enable_q,   // optics on
    output var  logic                     data_enable_q, // data path on
    output var  logic                     irq_q          // interrupt, high
);
    import status_led_pkg::*;

    logic [31:0] ctrl_q, limit_q, hours;
    logic [`EV_WIDTH-1:0] irq_stat_q, irq_mask_q, events, ev_prev_q;
    logic [`EV_WIDTH-1:0] ev_now;
    logic        aw_held_q, w_held_q, aw_held_d, w_held_d, bvalid_d;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write, ar_hs, oc_shut_q, flash_on;
    logic signed [9:0] t, lo, hi, m;
    logic        too_hot, too_cold, out_range, over_margin;

    // map a byte address onto a register
    function automatic reg_sel_t addr_sel(input logic [7:0] a);
        case (a)
            `OFF_CTRL:       addr_sel = SEL_CTRL;
            `OFF_TEMP_LIMIT: addr_sel = SEL_LIMIT;
            `OFF_STATE:      addr_sel = SEL_STATE;
            `OFF_IRQ_STATUS: addr_sel = SEL_IRQ;
            `OFF_IRQ_MASK:   addr_sel = SEL_MASK;
            `OFF_HOURS:      addr_sel = SEL_HOURS;
            default:         addr_sel = SEL_NONE;
        endcase
    endfunction

    // merge written bytes into a register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    // flash phase source
    flash_divider #(
        .HALF_CYCLES (FLASH_CYCLES)
    ) u_flash (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .flash_on_q (flash_on)
    );

    // out-of-range time accumulates while out of range
    hour_counter #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_hours (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (out_range),
        .hours_q (hours)
    );

    // temperature classification against software limits
    always_comb begin
        t = 10'(temp_celsius);
        lo = 10'(signed'(limit_q[`LIM_LOW_LSB +: 8]));
        hi = 10'(signed'(limit_q[`LIM_HIGH_LSB +: 8]));
        m = 10'sd`TEMP_MARGIN_C;
        too_hot = t > hi;
        too_cold = t < lo;
        out_range = too_hot | too_cold;
        over_margin = (t > hi + m) | (t < lo - m);
    end

    // write channel next state: address and data taken in either order
    always_comb begin
        aw_held_d = aw_held_q | (s_axi_awvalid & s_axi_awready);
        w_held_d  = w_held_q | (s_axi_wvalid & s_axi_wready);
        bvalid_d  = s_axi_bvalid & ~s_axi_bready;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
        end
    end
    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign ar_hs    = s_axi_arvalid & s_axi_arready;

    // write address and data capture, response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
        end else begin
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            s_axi_awready <= ~aw_held_d & ~bvalid_d;
            s_axi_wready  <= ~w_held_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= (addr_sel(awaddr_q) == SEL_NONE)
                             ? `RESP_SLVERR : `RESP_OKAY;
            end
        end
    end

    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= `CTRL_RESET;
            limit_q    <= `LIM_RESET;
            irq_mask_q <= '0;
        end else begin
            ctrl_q[`CTRL_OC_CLEAR] <= 1'b0; // clear bit self-clears
            if (do_write) begin
                case (addr_sel(awaddr_q))
                    SEL_CTRL:  ctrl_q  <= merge(ctrl_q, wdata_q, wstrb_q);
                    SEL_LIMIT: limit_q <= merge(limit_q, wdata_q, wstrb_q);
                    SEL_MASK: begin
                        if (wstrb_q[0]) begin
                            irq_mask_q <= wdata_q[`EV_WIDTH-1:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            case (addr_sel(s_axi_araddr))
                SEL_CTRL:  s_axi_rdata <= ctrl_q;
                SEL_LIMIT: s_axi_rdata <= limit_q;
                SEL_STATE: s_axi_rdata <= {26'h0, data_enable_q, tx_enable_q,
                                           oc_shut_q, over_margin,
                                           too_cold, too_hot};
                SEL_IRQ:   s_axi_rdata <= {28'h0, irq_stat_q};
                SEL_MASK:  s_axi_rdata <= {28'h0, irq_mask_q};
                SEL_HOURS: s_axi_rdata <= hours;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
        end
    end

    // overcurrent latches the transmitter off until software clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc_shut_q <= 1'b0;
        end else if (laser_overcur) begin
            oc_shut_q <= 1'b1;
        end else if (ctrl_q[`CTRL_OC_CLEAR]) begin
            oc_shut_q <= 1'b0;
        end
    end

    // optics and data path enables; temperature has no say here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_enable_q   <= 1'b0;
            data_enable_q <= 1'b0;
        end else begin
            tx_enable_q   <= ctrl_q[`CTRL_TX_EN] & ~oc_shut_q;
            data_enable_q <= ctrl_q[`CTRL_TX_EN];
        end
    end

    // event levels and their rising edges
    assign ev_now = {own_link_lost | own_sq_low | peer_fault,
                     laser_eol, oc_shut_q, out_range};
    assign events = ev_now & ~ev_prev_q;

    // sticky status, cleared by reading it; a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev_q  <= '0;
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            ev_prev_q <= ev_now;
            if (ar_hs && addr_sel(s_axi_araddr) == SEL_IRQ) begin
                irq_stat_q <= events;
            end else begin
                irq_stat_q <= irq_stat_q | events;
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // power light: device error red, heat warning flashing red
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_state_indicator <= LED_OFF;
        end else if (device_error) begin
            power_state_indicator <= LED_RED;
        end else if (too_hot && ctrl_q[`CTRL_WARN_EN]) begin
            power_state_indicator <= flash_on ? LED_RED : LED_OFF;
        end else begin
            power_state_indicator <= LED_GREEN;
        end
    end

    // temperature light: orange within margin, red beyond it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temperature_indicator <= LED_OFF;
        end else if (over_margin) begin
            temperature_indicator <= LED_RED;
        end else if (out_range) begin
            temperature_indicator <= LED_ORANGE;
        end else begin
            temperature_indicator <= LED_OFF;
        end
    end

    // laser light: overcurrent flashes, end of life steady
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            laser_health_indicator <= LED_OFF;
        end else if (oc_shut_q) begin
            laser_health_indicator <= flash_on ? LED_ORANGE : LED_OFF;
        end else if (laser_eol) begin
            laser_health_indicator <= LED_ORANGE;
        end else begin
            laser_health_indicator <= LED_OFF;
        end
    end

    // link error light: own fault red outranks peer fault orange
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_error_indicator <= LED_OFF;
        end else if (own_link_lost | own_sq_low) begin
            link_error_indicator <= LED_RED;
        end else if (peer_fault) begin
            link_error_indicator <= LED_ORANGE;
        end else begin
            link_error_indicator <= LED_OFF;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_power_flash: assert property (!device_error && too_hot &&
        ctrl_q[`CTRL_WARN_EN] |=> power_state_indicator ==
        ($past(flash_on) ? LED_RED : LED_OFF))
        else $error("power light not flashing red when hot");
    a_temp_orange: assert property (out_range && !over_margin |=>
        temperature_indicator == LED_ORANGE)
        else $error("temperature light not orange within margin");
    a_temp_red: assert property (over_margin |=>
        temperature_indicator == LED_RED)
        else $error("temperature light not red beyond margin");
    a_data_kept: assert property (ctrl_q[`CTRL_TX_EN] && out_range
        ##1 ctrl_q[`CTRL_TX_EN] |=> data_enable_q)
        else $error("data path dropped on temperature");
    a_laser_eol: assert property (laser_eol && !oc_shut_q |=>
        laser_health_indicator == LED_ORANGE)
        else $error("laser light not orange at end of life");
    a_oc_shutdown: assert property (laser_overcur |=> oc_shut_q
        ##1 !tx_enable_q)
        else $error("transmitter not off after overcurrent");
    a_link_peer: assert property (peer_fault && !own_link_lost &&
        !own_sq_low |=> link_error_indicator == LED_ORANGE)
        else $error("link light not orange on peer fault");
    a_link_own: assert property (own_link_lost || own_sq_low |=>
        link_error_indicator == LED_RED)
        else $error("link light not red on own fault");
    a_flash_steady: assert property ($rose(flash_on) |=>
        flash_on [*8])
        else $error("flash phase too short");
    a_irq_level: assert property ((irq_stat_q & irq_mask_q) != '0 |=>
        irq_q) else $error("interrupt not raised");
    a_write_resp: assert property (do_write |=> s_axi_bvalid)
        else $error("write not answered");

    c_hot_flash: cover property (too_hot && power_state_indicator
        == LED_RED);
    c_oc_trip: cover property ($rose(oc_shut_q));
    c_irq: cover property ($rose(irq_q));
    c_read_irq: cover property (ar_hs && addr_sel(s_axi_araddr) == SEL_IRQ);

endmodule // status_led_diagnostics

`default_nettype wire

// file: status_led_pkg.sv
/*
 * Types shared by the panel indicator design files.
 * Assumes nothing of its surroundings.
 */
package status_led_pkg;

    // indicator colour, two bits per panel light
    typedef enum logic [1:0] {
        LED_OFF    = 2'b00,
        LED_GREEN  = 2'b01,
        LED_ORANGE = 2'b10,
        LED_RED    = 2'b11
    } led_color_t;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_CTRL   = 3'b000,
        SEL_LIMIT  = 3'b001,
        SEL_STATE  = 3'b010,
        SEL_IRQ    = 3'b011,
        SEL_MASK   = 3'b100,
        SEL_HOURS  = 3'b101,
        SEL_NONE   = 3'b111
    } reg_sel_t;

endpackage

// file: tb.sv
/*
 * Self-checking bench of the panel indicator block.
 * Assumes the design files and panel_watch are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "status_led_cfg.svh"

module tb;
    import status_led_pkg::*;
    localparam int FL = 16;    // flash half period in cycles
    localparam int HR = 36000; // one hour at ten cycles a second
    localparam int HI = (`LIM_RESET >> `LIM_HIGH_LSB) & 255;
    localparam int LO = `LIM_RESET & 255;
    logic        aclk = 0, aresetn = 0, clr = 0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, tx_enable_q, data_enable_q;
    logic        irq_q, device_error, laser_eol, laser_overcur;
    logic        own_link_lost, own_sq_low, peer_fault;
    logic signed [7:0] temp_celsius;
    led_color_t  power_state_indicator, temperature_indicator;
    led_color_t  laser_health_indicator, link_error_indicator;
    led_color_t  leds [4];
    led_color_t  want = LED_OFF;
    int          bad_count = 0, num_checks = 0, seed = 10583, wsel = 0;
    int          hits;
    int          tq[$] = '{55, 56, 60, -5, -6, -20};
    logic [2:0]  lk [4] = '{3'b100, 3'b010, 3'b001, 3'b110};

    // free-running clock, 8 ns period
    always #4 aclk = ~aclk;

    // lights offered to the panel observer
    assign leds = '{power_state_indicator, temperature_indicator,
                    laser_health_indicator, link_error_indicator};

    status_led_diagnostics #(.SEC_CYCLES(10), .FLASH_CYCLES(FL)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .temp_celsius, .device_error,
        .laser_eol, .laser_overcur, .own_link_lost, .own_sq_low,
        .peer_fault, .power_state_indicator, .temperature_indicator,
        .laser_health_indicator, .link_error_indicator, .tx_enable_q,
        .data_enable_q, .irq_q);

    panel_watch P (.aclk, .clr, .led(leds[wsel]), .want, .hits);

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // one bus edge with a bound on the whole wait
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 60) begin
            bad_count++;
            final_report();
        end
    endtask

    // write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       output logic [1:0] r);
        bit ad, dd;
        int n;
        ad = 0;
        dd = 0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && dd)) begin
            step(n);
            if (!ad && s_axi_awready === 1'b1) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (!dd && s_axi_wready === 1'b1) begin
                dd = 1;
                s_axi_wvalid <= 0;
            end
        end
        do step(n); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do step(n); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do step(n); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  r;
        axr(a, v, r);
        chk("rdata", v, e);
        chk("rresp", r, `RESP_OKAY);
    endtask

    // count lit cycles of one light over two flash phases
    task automatic watch(input int w, input led_color_t c, input int e);
        wsel <= w;
        want <= c;
        clr <= 1;
        @(posedge aclk);
        clr <= 0;
        tick(2 * FL + 1);
        chk("lit", hits, e);
    endtask

    // reference colour of the temperature light out of range
    function automatic int exp_temp(input int t);
        if (t > HI + `TEMP_MARGIN_C || t < LO - `TEMP_MARGIN_C)
            return LED_RED;
        return LED_ORANGE;
    endfunction

    // main sequence
    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, s_axi_wstrb, device_error, laser_eol} = 38'h3C;
        {laser_overcur, own_link_lost, own_sq_low, peer_fault} = 4'h0;
        temp_celsius = 8'sd25;
        tick(10);
        aresetn <= 1;
        tick(3);
        chk("tx", tx_enable_q, 1);
        chk("data", data_enable_q, 1);
        chk("power", power_state_indicator, LED_GREEN);
        rdc(`OFF_CTRL, `CTRL_RESET);
        rdc(`OFF_TEMP_LIMIT, `LIM_RESET);
        rdc(`OFF_STATE, 32'h30);
        rdc(`OFF_IRQ_STATUS, 32'h0);
        rdc(`OFF_HOURS, 32'h0);
        axr(8'h18, v, r);
        chk("rresp", r, `RESP_SLVERR);
        axw(8'h18, 32'hFFFF_FFFF, r);
        chk("bresp", r, `RESP_SLVERR);
        axw(`OFF_IRQ_MASK, 32'hF, r);
        foreach (tq[i]) begin
            temp_celsius <= 8'(tq[i]);
            tick(3);
            chk("temp", temperature_indicator, exp_temp(tq[i]));
            chk("data", data_enable_q, 1);
            watch(0, LED_RED, tq[i] > HI ? FL : 0);
            chk("irq", irq_q, 1);
            rdc(`OFF_IRQ_STATUS, 32'h1);
            tick(3);
            chk("irq", irq_q, 0);
            temp_celsius <= 8'(10 + $unsigned($random(seed)) % 31);
            tick(3);
        end
        axw(`OFF_CTRL, 32'h1, r);
        temp_celsius <= 8'sd60;
        tick(3);
        watch(0, LED_GREEN, 2 * FL);
        rdc(`OFF_IRQ_STATUS, 32'h1);
        axw(`OFF_CTRL, `CTRL_RESET, r);
        temp_celsius <= 8'sd30;
        laser_eol <= 1;
        tick(3);
        watch(2, LED_ORANGE, 2 * FL);
        laser_overcur <= 1;
        tick(1);
        laser_overcur <= 0;
        tick(3);
        chk("tx", tx_enable_q, 0);
        chk("data", data_enable_q, 1);
        watch(2, LED_ORANGE, FL);
        rdc(`OFF_IRQ_STATUS, 32'h6);
        axw(`OFF_CTRL, 32'h7, r);
        tick(3);
        chk("tx", tx_enable_q, 1);
        watch(2, LED_ORANGE, 2 * FL);
        laser_eol <= 0;
        axw(`OFF_IRQ_MASK, 32'h7, r);
        foreach (lk[i]) begin
            {peer_fault, own_link_lost, own_sq_low} <= lk[i];
            tick(3);
            chk("link", link_error_indicator,
                (lk[i][1:0] != 0) ? LED_RED : LED_ORANGE);
            chk("irq", irq_q, 0);
            {peer_fault, own_link_lost, own_sq_low} <= 3'h0;
            tick(2);
        end
        rdc(`OFF_IRQ_STATUS, 32'h8);
        temp_celsius <= 8'sd60;
        tick(HR + 100);
        rdc(`OFF_HOURS, 32'h1);
        chk("data", data_enable_q, 1);
        device_error <= 1;
        tick(3);
        watch(0, LED_RED, 2 * FL);
        final_report();
    end
endmodule // tb

`default_nettype wire
